// *** ltx_consts.svh ***
// Purpose: Offsets, field positions, reset values and symbols of the link transmitter
// Assumes: Included by bare name from the encoder and top-level design files
// Notes: Definitions only
`ifndef LTX_CONSTS_SVH
`define LTX_CONSTS_SVH
// ****************************************
// Register map
// ****************************************
`define LTX_OFS_LANE_RATE 15'h056E
`define LTX_OFS_PLL_STAT 15'h056F
`define LTX_OFS_QUICK_CFG 15'h0570
`define LTX_OFS_LINK_CTRL 15'h0571
`define LTX_OFS_LINK_STAT 15'h0572
`define LTX_RST_LANE_RATE 8'h00
`define LTX_RST_QUICK_CFG 8'h48
`define LTX_RST_LINK_CTRL 8'h03
`define LTX_PLL_LOCK_BIT 7
`define LTX_CTL_SCR 0
`define LTX_CTL_FRAME_ALIGN_SUBSTITUTION 1
`define LTX_CTL_BYP 2
`define LTX_CTL_INV 3
`define LTX_CTL_FMT 4
`define LTX_CTL_PDN 5
`define LTX_CTL_DEEMPH 6
`define LTX_QC_LANES 6
// ****************************************
// Framing and symbols
// ****************************************
`define LTX_K_LAST 5'd31
`define LTX_INITIAL_LANE_ALIGNMENT_LAST 2'd3
`define LTX_CH_R 8'h1C
`define LTX_CH_A 8'h7C
`define LTX_CH_Q 8'h9C
`define LTX_CH_K 8'hBC
`define LTX_CH_F 8'hFC
`define LTX_SUB_F 8'hFC
`define LTX_SUB_A 8'hFD
`define LTX_SPI_HDR 5'd16
`define LTX_SPI_BITS 5'd24
`endif

// *** ltx_enc8b10b.sv ***
// Purpose: Octet to 10-bit symbol encoder with running disparity
// Assumes: k_i only with octet 8'h1C..8'hFC of the K28 group
// Notes: Output registered; bypass and invert for front-end debug
`include "ltx_consts.svh"
module ltx_enc8b10b import ltx_pkg::*; (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [7:0] octet_i,
	input wire logic k_i,
	input wire logic bypass_i,
	input wire logic invert_i,
	input wire logic blank_i,
	output logic [9:0] sym_o
);
	localparam logic [5:0] T6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] T4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
	logic rd_q, rd_d, rd_m;
	logic [9:0] sym_q, sym_d;
	logic [5:0] c6;
	logic [3:0] c4;
	logic [4:0] x;
	logic [2:0] y;
	logic u4;

	// ****************************************
	// Code selection
	// ****************************************
	// Sub-block choice follows running disparity
	always_comb begin
		x = octet_i[4:0];
		y = octet_i[7:5];
		c6 = k_i ? 6'h0F : T6[x];
		if (rd_q && (ltx_ones({4'h0, c6}) != 4'd3 || (x == 5'd7 && !k_i))) begin
			c6 = ~c6;
		end
		rd_m = (ltx_ones({4'h0, c6}) == 4'd3) ? rd_q : !rd_q;
		c4 = T4[y];
		if (y == 3'd7 && (k_i || (!rd_m && (x == 5'd17 || x == 5'd18 || x == 5'd20))
				|| (rd_m && (x == 5'd11 || x == 5'd13 || x == 5'd14)))) begin
			c4 = 4'h7;
		end
		u4 = (ltx_ones({6'h00, c4}) != 4'd2) || y == 3'd3;
		if (k_i ? (u4 ^ !rd_m) : (rd_m && u4)) begin
			c4 = ~c4;
		end
		sym_d = {c6, c4};
		rd_d = rd_q;
		if (ltx_ones(sym_d) > 4'd5) begin
			rd_d = 1'b1;
		end else if (ltx_ones(sym_d) < 4'd5) begin
			rd_d = 1'b0;
		end
		if (bypass_i) begin
			sym_d = {2'b00, octet_i};
			rd_d = rd_q;
		end
		if (invert_i) begin
			sym_d = ~sym_d;
		end
		if (blank_i) begin
			sym_d = 10'h000;
			rd_d = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			rd_q <= 1'b0;
			sym_q <= 10'h000;
		end else begin
			rd_q <= rd_d;
			sym_q <= sym_d;
		end
	end

	assign sym_o = sym_q;

	// ****************************************
	// Checks
	// ****************************************
	a_enc_disparity: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(!bypass_i && !invert_i && !blank_i) |=> (ltx_ones(sym_o) == 4'd5
		|| (ltx_ones(sym_o) == 4'd6 && !$past(rd_q)) || (ltx_ones(sym_o) == 4'd4 && $past(rd_q))))
		else $error("symbol disparity does not match running disparity");
	a_enc_bypass_inv: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(bypass_i && invert_i && !blank_i) |=> sym_o == ~{2'b00, $past(octet_i)})
		else $error("bypass with invert gives wrong symbol");
endmodule // ltx_enc8b10b

// *** ltx_fifo.sv ***
// Purpose: Sample buffer with registered read data
// Assumes: Producer holds data while valid is high and ready low
// Notes: Two cycles from write to visible output
module ltx_fifo #(
	parameter int W = 16,
	parameter int D = 16
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	ltx_stream_if.src out_if
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic rdy_q, rdy_d, vld_q, vld_d;
	logic [W-1:0] dat_q, dat_d;
	logic push, load;

	// ****************************************
	// Pointers and occupancy
	// ****************************************
	// Ready is registered so the source sees a clean flop
	always_comb begin
		push = in_valid_i && rdy_q;
		load = (!vld_q || out_if.ready) && (cnt_q != '0);
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = load ? rp_q + 1'b1 : rp_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(load);
		// Output register counts as one slot, so the buffer holds exactly D words
		rdy_d = ((AW+2)'(cnt_d) + (AW+2)'(vld_d)) != (AW+2)'(D);
		vld_d = load || (vld_q && !out_if.ready);
		dat_d = load ? mem[rp_q] : dat_q;
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			rdy_q <= 1'b0;
			vld_q <= 1'b0;
			dat_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			rdy_q <= rdy_d;
			vld_q <= vld_d;
			dat_q <= dat_d;
		end
	end

	// Storage carries no reset
	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem[wp_q] <= in_data_i;
		end
	end

	assign in_ready_o = rdy_q;
	assign out_if.valid = vld_q;
	assign out_if.data = dat_q;
endmodule // ltx_fifo

// *** ltx_link_top.sv ***
// Purpose: Two-link transmit data link layer with serial register port
// Assumes: One octet per lane per clock; inputs synchronous to mclk_i
// Notes: Serial port frame is R/W, 15-bit address, 8-bit data
`include "ltx_consts.svh"
module ltx_link_top import ltx_pkg::*; (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic spi_sclk_i,
	input wire logic spi_csn_i,
	input wire logic spi_sdio_i,
	output logic spi_sdio_o,
	output logic spi_sdio_oe_o,
	input wire logic sync_request_n_pair0_i,
	input wire logic sync_request_n_pair1_i,
	input wire logic pll_lock_i,
	input wire logic [15:0] link0_samples_i,
	input wire logic link0_valid_i,
	output logic link0_ready_o,
	input wire logic [15:0] link1_samples_i,
	input wire logic link1_valid_i,
	output logic link1_ready_o,
	output logic [9:0] lane0_pair0_out_o,
	output logic [9:0] lane1_pair0_out_o,
	output logic [9:0] lane0_pair1_out_o,
	output logic [9:0] lane1_pair1_out_o,
	output logic [3:0] lane_rate_o,
	output logic deemph_en_o,
	output logic lanes_pdn_o
);
	// Serial port state
	logic sclk_q, rd_q, rd_d, sdo_q, sdo_d, oe_q, oe_d, rise, fall;
	logic [23:0] sh_q, sh_d, nxt;
	logic [4:0] cnt_q, cnt_d;
	logic [7:0] tx_q, tx_d, rdat;
	logic [7:0] lrate_q, lrate_d, qcfg_q, qcfg_d, ctrl_q, ctrl_d;
	// Link state
	ltx_state_e st_q [2], st_d [2];
	logic [2:0] oct_q [2], oct_d [2], fl;
	logic [4:0] frm_q [2], frm_d [2];
	logic [1:0] mf_q [2], mf_d [2];
	logic [7:0] ramp_q [2], ramp_d [2];
	logic ph_q [2], ph_d [2];
	logic end_fr [2], end_mf [2], pop [2], sv [2], syn [2], rdy [2], lanes2, lane_on;
	logic [15:0] smp [2], in_d [2];
	logic in_v [2];
	// Lane state
	logic [14:0] scr_q [4], scr_d [4], scr_nx [4];
	logic [7:0] prev_q [4], prev_d [4], smp_oct [4], scr_oct [4], lane_oct [4];
	logic lane_k [4];
	logic [9:0] sym [4];

	assign syn[0] = sync_request_n_pair0_i;
	assign syn[1] = sync_request_n_pair1_i;
	assign in_d[0] = link0_samples_i;
	assign in_d[1] = link1_samples_i;
	assign in_v[0] = link0_valid_i;
	assign in_v[1] = link1_valid_i;

	// ****************************************
	// Serial register port
	// ****************************************
	// Clock edges found by sampling; read data leaves on falling edges
	always_comb begin
		rise = spi_sclk_i && !sclk_q;
		fall = !spi_sclk_i && sclk_q;
		nxt = {sh_q[22:0], spi_sdio_i};
		sh_d = sh_q;
		cnt_d = cnt_q;
		tx_d = tx_q;
		rd_d = rd_q;
		sdo_d = sdo_q;
		oe_d = oe_q;
		lrate_d = lrate_q;
		qcfg_d = qcfg_q;
		ctrl_d = ctrl_q;
		rdat = 8'h00;
		if (nxt[14:0] == `LTX_OFS_LANE_RATE) begin
			rdat = lrate_q;
		end else if (nxt[14:0] == `LTX_OFS_PLL_STAT) begin
			rdat[`LTX_PLL_LOCK_BIT] = pll_lock_i;
		end else if (nxt[14:0] == `LTX_OFS_QUICK_CFG) begin
			rdat = qcfg_q;
		end else if (nxt[14:0] == `LTX_OFS_LINK_CTRL) begin
			rdat = ctrl_q;
		end else if (nxt[14:0] == `LTX_OFS_LINK_STAT) begin
			rdat = {4'h0, st_q[1], st_q[0]};
		end
		if (spi_csn_i) begin
			cnt_d = 5'd0;
			oe_d = 1'b0;
			rd_d = 1'b0;
		end else begin
			if (rise && cnt_q != `LTX_SPI_BITS) begin
				sh_d = nxt;
				cnt_d = cnt_q + 5'd1;
				if (cnt_q == `LTX_SPI_HDR - 5'd1) begin
					rd_d = nxt[15];
					tx_d = rdat;
				end
				// Writes land on the last data bit
				if (cnt_q == `LTX_SPI_BITS - 5'd1 && !rd_q) begin
					if (nxt[22:8] == `LTX_OFS_LANE_RATE) begin
						lrate_d = nxt[7:0];
					end else if (nxt[22:8] == `LTX_OFS_QUICK_CFG) begin
						qcfg_d = nxt[7:0];
					end else if (nxt[22:8] == `LTX_OFS_LINK_CTRL) begin
						ctrl_d = nxt[7:0];
					end
				end
			end
			if (fall && rd_q && cnt_q >= `LTX_SPI_HDR && cnt_q != `LTX_SPI_BITS) begin
				sdo_d = tx_q[7];
				tx_d = {tx_q[6:0], 1'b0};
				oe_d = 1'b1;
			end
		end
	end

	// Defaults: scrambling and substitution on, lanes up, de-emphasis off
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			sclk_q <= 1'b0;
			sh_q <= 24'h000000;
			cnt_q <= 5'd0;
			tx_q <= 8'h00;
			rd_q <= 1'b0;
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
			lrate_q <= `LTX_RST_LANE_RATE;
			qcfg_q <= `LTX_RST_QUICK_CFG;
			ctrl_q <= `LTX_RST_LINK_CTRL;
		end else begin
			sclk_q <= spi_sclk_i;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			tx_q <= tx_d;
			rd_q <= rd_d;
			sdo_q <= sdo_d;
			oe_q <= oe_d;
			lrate_q <= lrate_d;
			qcfg_q <= qcfg_d;
			ctrl_q <= ctrl_d;
		end
	end

	// ****************************************
	// Link framing and octet path
	// ****************************************
	// Multiframe counters free run; they are the local multiframe clock
	always_comb begin
		fl = 3'((4'd1 << qcfg_q[1:0]) - 4'd1);
		lanes2 = qcfg_q[`LTX_QC_LANES];
		lane_on = 1'b0;
		for (int l = 0; l < 2; l++) begin
			end_fr[l] = oct_q[l] == fl;
			end_mf[l] = end_fr[l] && frm_q[l] == `LTX_K_LAST;
			oct_d[l] = end_fr[l] ? 3'd0 : oct_q[l] + 3'd1;
			frm_d[l] = end_mf[l] ? 5'd0 : (end_fr[l] ? frm_q[l] + 5'd1 : frm_q[l]);
			st_d[l] = st_q[l];
			mf_d[l] = mf_q[l];
			ramp_d[l] = ramp_q[l] + 8'd1;
			ph_d[l] = 1'b0;
			pop[l] = 1'b0;
			case (st_q[l])
				ST_CGS: begin
					if (syn[l] && end_mf[l]) begin
						st_d[l] = ST_INITIAL_LANE_ALIGNMENT;
						mf_d[l] = 2'd0;
						ramp_d[l] = 8'd0;
					end
				end
				ST_INITIAL_LANE_ALIGNMENT: begin
					if (end_mf[l]) begin
						ramp_d[l] = 8'd0;
						mf_d[l] = mf_q[l] + 2'd1;
						if (mf_q[l] == `LTX_INITIAL_LANE_ALIGNMENT_LAST) begin
							st_d[l] = ST_DATA;
						end
					end
				end
				ST_DATA: begin
					pop[l] = lanes2 || ph_q[l];
					ph_d[l] = !lanes2 && !ph_q[l];
				end
				default: begin
					st_d[l] = ST_CGS;
				end
			endcase
			if (!syn[l] || ctrl_q[`LTX_CTL_PDN]) begin
				st_d[l] = ST_CGS;
			end
			for (int j = 0; j < 2; j++) begin
				// Low byte is converter 0 (first ADC), high byte converter 1
				smp_oct[l*2+j] = ((lanes2 ? j[0] : ph_q[l]) ? smp[l][15:8] : smp[l][7:0]);
				if (!sv[l]) begin
					smp_oct[l*2+j] = 8'h00;
				end
				smp_oct[l*2+j][7] = smp_oct[l*2+j][7] ^ ctrl_q[`LTX_CTL_FMT];
				{scr_nx[l*2+j], scr_oct[l*2+j]} = ltx_scr8(smp_oct[l*2+j], scr_q[l*2+j]);
				scr_d[l*2+j] = scr_q[l*2+j];
				prev_d[l*2+j] = prev_q[l*2+j];
				lane_k[l*2+j] = 1'b1;
				lane_oct[l*2+j] = `LTX_CH_K;
				lane_on = lanes2 || j == 0;
				if (st_q[l] == ST_INITIAL_LANE_ALIGNMENT && lane_on) begin
					// Ramp fill, never scrambled
					lane_k[l*2+j] = 1'b0;
					lane_oct[l*2+j] = ramp_q[l];
					if (ramp_q[l] == 8'd0) begin
						lane_k[l*2+j] = 1'b1;
						lane_oct[l*2+j] = `LTX_CH_R;
					end else if (end_mf[l]) begin
						lane_k[l*2+j] = 1'b1;
						lane_oct[l*2+j] = `LTX_CH_A;
					end else if (mf_q[l] == 2'd1 && ramp_q[l] == 8'd1) begin
						lane_k[l*2+j] = 1'b1;
						lane_oct[l*2+j] = `LTX_CH_Q;
					end
				end else if (st_q[l] == ST_DATA && lane_on) begin
					lane_k[l*2+j] = 1'b0;
					lane_oct[l*2+j] = smp_oct[l*2+j];
					if (ctrl_q[`LTX_CTL_SCR]) begin
						lane_oct[l*2+j] = scr_oct[l*2+j];
						scr_d[l*2+j] = scr_nx[l*2+j];
					end
					if (end_fr[l]) begin
						prev_d[l*2+j] = smp_oct[l*2+j];
					end
					if (ctrl_q[`LTX_CTL_FRAME_ALIGN_SUBSTITUTION] && end_fr[l]) begin
						if (ctrl_q[`LTX_CTL_SCR]) begin
							if (scr_oct[l*2+j] == `LTX_SUB_F) begin
								lane_k[l*2+j] = 1'b1;
								lane_oct[l*2+j] = `LTX_CH_F;
							end else if (end_mf[l] && scr_oct[l*2+j] == `LTX_SUB_A) begin
								lane_k[l*2+j] = 1'b1;
								lane_oct[l*2+j] = `LTX_CH_A;
							end
						end else if (smp_oct[l*2+j] == prev_q[l*2+j]) begin
							lane_k[l*2+j] = 1'b1;
							lane_oct[l*2+j] = end_mf[l] ? `LTX_CH_A : `LTX_CH_F;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			for (int l = 0; l < 2; l++) begin
				st_q[l] <= ST_CGS;
				oct_q[l] <= 3'd0;
				frm_q[l] <= 5'd0;
				mf_q[l] <= 2'd0;
				ramp_q[l] <= 8'd0;
				ph_q[l] <= 1'b0;
			end
			for (int n = 0; n < 4; n++) begin
				scr_q[n] <= 15'h0000;
				prev_q[n] <= 8'h00;
			end
		end else begin
			st_q <= st_d;
			oct_q <= oct_d;
			frm_q <= frm_d;
			mf_q <= mf_d;
			ramp_q <= ramp_d;
			ph_q <= ph_d;
			scr_q <= scr_d;
			prev_q <= prev_d;
		end
	end

	// ****************************************
	// Buffers and encoders
	// ****************************************
	// Buffer absorbs sample bursts while the link is not in user data
	for (genvar l = 0; l < 2; l++) begin : g_link
		ltx_stream_if #(.W(16)) s_if ();
		ltx_fifo #(.W(16), .D(16)) u_fifo (
			.mclk_i(mclk_i),
			.resetn_i(resetn_i),
			.in_data_i(in_d[l]),
			.in_valid_i(in_v[l]),
			.in_ready_o(rdy[l]),
			.out_if(s_if)
		);
		assign smp[l] = s_if.data;
		assign sv[l] = s_if.valid;
		assign s_if.ready = pop[l];
	end

	for (genvar n = 0; n < 4; n++) begin : g_lane
		ltx_enc8b10b u_enc (
			.mclk_i(mclk_i),
			.resetn_i(resetn_i),
			.octet_i(lane_oct[n]),
			.k_i(lane_k[n]),
			.bypass_i(ctrl_q[`LTX_CTL_BYP]),
			.invert_i(ctrl_q[`LTX_CTL_INV]),
			.blank_i(ctrl_q[`LTX_CTL_PDN]),
			.sym_o(sym[n])
		);
	end

	assign lane0_pair0_out_o = sym[0];
	assign lane1_pair0_out_o = sym[1];
	assign lane0_pair1_out_o = sym[2];
	assign lane1_pair1_out_o = sym[3];
	assign link0_ready_o = rdy[0];
	assign link1_ready_o = rdy[1];
	assign spi_sdio_o = sdo_q;
	assign spi_sdio_oe_o = oe_q;
	assign lane_rate_o = lrate_q[7:4];
	assign deemph_en_o = ctrl_q[`LTX_CTL_DEEMPH];
	assign lanes_pdn_o = ctrl_q[`LTX_CTL_PDN];

	// ****************************************
	// Checks
	// ****************************************
	a_ctrl_defaults: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		$rose(resetn_i) |-> ctrl_q[`LTX_CTL_SCR] && ctrl_q[`LTX_CTL_FRAME_ALIGN_SUBSTITUTION]
		&& !lanes_pdn_o && !deemph_en_o)
		else $error("control defaults wrong after reset");
	a_cgs_sync_char: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		st_q[0] == ST_CGS |-> lane_k[0] && lane_oct[0] == `LTX_CH_K)
		else $error("sync phase not sending sync characters");
	a_initial_lane_alignment_on_boundary: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(st_q[0] == ST_INITIAL_LANE_ALIGNMENT && $past(st_q[0]) == ST_CGS) |-> oct_q[0] == 3'd0 && frm_q[0] == 5'd0)
		else $error("alignment sequence not on multiframe boundary");
	a_initial_lane_alignment_four_mf: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(st_q[0] == ST_INITIAL_LANE_ALIGNMENT && mf_q[0] == 2'd3 && end_mf[0] && sync_request_n_pair0_i
		&& !ctrl_q[`LTX_CTL_PDN]) |=> st_q[0] == ST_DATA)
		else $error("alignment sequence length wrong");
	a_initial_lane_alignment_plain: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(st_q[0] == ST_INITIAL_LANE_ALIGNMENT && !lane_k[0]) |-> lane_oct[0] == ramp_q[0])
		else $error("alignment sequence data altered");
	a_user_data: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(st_q[0] == ST_DATA && !end_fr[0]) |-> !lane_k[0])
		else $error("control character inside a frame");
	a_sub_frame: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(st_q[0] == ST_DATA && ctrl_q[1:0] == 2'b11 && end_fr[0] && scr_oct[0] == `LTX_SUB_F)
		|-> lane_k[0] && lane_oct[0] == `LTX_CH_F)
		else $error("frame end FC not substituted");
	a_sub_multi: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(st_q[0] == ST_DATA && ctrl_q[1:0] == 2'b11 && end_mf[0] && scr_oct[0] == `LTX_SUB_A)
		|-> lane_k[0] && lane_oct[0] == `LTX_CH_A)
		else $error("multiframe end FD not substituted");
	a_sub_repeat: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(st_q[0] == ST_DATA && ctrl_q[1:0] == 2'b10 && end_fr[0] && smp_oct[0] == prev_q[0])
		|-> lane_k[0] && lane_oct[0] == (end_mf[0] ? `LTX_CH_A : `LTX_CH_F))
		else $error("repeated frame end not substituted");
endmodule // ltx_link_top

// *** ltx_pkg.sv ***
// Purpose: Types and shared arithmetic of the link transmitter
// Assumes: Nothing
// Notes: Scrambler is 1 + x^14 + x^15, MSB first
package ltx_pkg;
	typedef enum logic [1:0] {ST_CGS = 2'b00, ST_INITIAL_LANE_ALIGNMENT = 2'b01, ST_DATA = 2'b10} ltx_state_e;

	// Count of ones in a symbol
	function automatic logic [3:0] ltx_ones(input logic [9:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 10; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction

	// Scramble one octet, returns {next state, octet}
	function automatic logic [22:0] ltx_scr8(input logic [7:0] d, input logic [14:0] s);
		logic [14:0] st;
		logic [7:0] o;
		st = s;
		o = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			o[i] = d[i] ^ st[13] ^ st[14];
			st = {st[13:0], o[i]};
		end
		return {st, o};
	endfunction
endpackage

// *** ltx_rx_model.sv ***
// Purpose: Receiver side of one link, drives the sync request
// Assumes: One lane symbol per clock on lane 0
// Notes: Raw octet BC counts too, so the encoder bypass can be exercised
module ltx_rx_model (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [9:0] sym_i,
	output logic sync_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] k_cnt;
	logic is_k;
	// ****************************************
	// Code group lock
	// ****************************************
	// Sync character in either disparity, or raw in bypass
	assign is_k = (sym_i == 10'h0FA) || (sym_i == 10'h305) || (sym_i == 10'h0BC);
	// Hold request low until four clean sync characters are seen
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			k_cnt <= 3'h0;
			sync_n_o <= 1'b0;
		end else if (sync_n_o == 1'b0) begin
			k_cnt <= is_k ? k_cnt + 3'h1 : 3'h0;
			sync_n_o <= (k_cnt == 3'h4);
		end
	end
endmodule // ltx_rx_model

// *** ltx_stream_if.sv ***
// Purpose: Valid/ready word stream between design modules
// Assumes: Single clock domain
// Notes: Word taken when valid and ready are both high
interface ltx_stream_if #(parameter int W = 16) ();
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface

// *** tb.sv ***
// Purpose: Self-checking bench of the link transmitter
// Assumes: Inputs change at the falling edge
// Notes: Encoder bypass makes lane octets visible
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 0, resetn_i = 0, sclk = 0, csn = 1, sdio = 0, pll = 0, val = 0;
	logic sdo, sdo_oe, rdy0, rdy1, deemph, pdn, sync0, sync1;
	logic [9:0] l00, l10, l01, l11, s;
	logic [3:0] rate;
	logic [7:0] q;
	logic [15:0] smp = 16'h0000;
	logic [15:0] words [16];
	logic [31:0] rnd = 32'h2F4A;
	int bad_count = 0, checks = 0, n;
	ltx_link_top i_ltx_link_top (.mclk_i(mclk_i), .resetn_i(resetn_i), .spi_sclk_i(sclk),
		.spi_csn_i(csn), .spi_sdio_i(sdo_oe ? sdo : sdio), .spi_sdio_o(sdo),
		.spi_sdio_oe_o(sdo_oe), .sync_request_n_pair0_i(sync0),
		.sync_request_n_pair1_i(sync1), .pll_lock_i(pll), .link0_samples_i(smp),
		.link0_valid_i(val), .link0_ready_o(rdy0), .link1_samples_i(smp),
		.link1_valid_i(val), .link1_ready_o(rdy1), .lane0_pair0_out_o(l00),
		.lane1_pair0_out_o(l10), .lane0_pair1_out_o(l01), .lane1_pair1_out_o(l11),
		.lane_rate_o(rate), .deemph_en_o(deemph), .lanes_pdn_o(pdn));
	ltx_rx_model i_ltx_rx_model_0 (.mclk_i(mclk_i), .resetn_i(resetn_i), .sym_i(l00),
		.sync_n_o(sync0));
	ltx_rx_model i_ltx_rx_model_1 (.mclk_i(mclk_i), .resetn_i(resetn_i), .sym_i(l01),
		.sync_n_o(sync1));
	// ****************************************
	// Helpers
	// ****************************************
	always #20 mclk_i = ~mclk_i;
	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Bypassed symbol of an octet, offset binary flips the MSB
	function automatic logic [9:0] byp(input logic [7:0] b, input logic fmt);
		return {2'b00, b ^ {fmt, 7'h00}};
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One 24-bit frame, sclk held 3 low and 2 high, read bits land in q
	task automatic spi(input logic rw, input logic [14:0] a, input logic [7:0] d);
		logic [23:0] f;
		f = {rw, a, d};
		csn = 0;
		for (int i = 23; i >= 0; i--) begin
			sdio = f[i];
			sclk = 0;
			repeat (3) @(negedge mclk_i);
			if (i < 8)
				q = {q[6:0], sdo};
			sclk = 1;
			repeat (2) @(negedge mclk_i);
		end
		sclk = 0;
		repeat (3) @(negedge mclk_i);
		csn = 1;
		repeat (2) @(negedge mclk_i);
	endtask
	task automatic rdc(input string nm, input logic [14:0] a, input logic [7:0] e);
		spi(1'b1, a, 8'h00);
		chk(nm, e, q);
	endtask
	// Bounded wait for a symbol on lane 0 of link 0
	task automatic seek(input logic [9:0] e);
		n = 0;
		while (l00 !== e && n < 2000) begin
			@(negedge mclk_i);
			n++;
		end
	endtask
	task automatic end_sim();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Run takes about 1900 cycles, the limit of 80000 cycles is about forty times that
	initial begin
		#3200000;
		bad_count++;
		end_sim();
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (16) @(negedge mclk_i);
		resetn_i = 1;
		repeat (4) @(negedge mclk_i);
		s = l00;
		@(negedge mclk_i);
		chk("k_sym", 1, s === 10'h0FA || s === 10'h305);
		chk("k_disp", 10'h3FF, s ^ l00);
		chk("pdn", 0, pdn);
		chk("deemph", 0, deemph);
		rdc("rate_rst", 15'h056E, 8'h00);
		rdc("qcfg_rst", 15'h0570, 8'h48);
		rdc("ctrl_rst", 15'h0571, 8'h03);
		rdc("unmapped", 15'h0100, 8'h00);
		rdc("pll_low", 15'h056F, {1'b0, q[6:0]});
		pll = 1;
		spi(1'b0, 15'h056F, 8'h00);
		rdc("pll_ro", 15'h056F, {1'b1, q[6:0]});
		spi(1'b0, 15'h056E, 8'h10);
		chk("rate", 4'h1, rate);
		rdc("rate_rd", 15'h056E, 8'h10);
		// Power down, fill the buffer while the link cannot drain it
		spi(1'b0, 15'h0571, 8'h70);
		chk("pdn_on", 1, pdn);
		chk("deemph_on", 1, deemph);
		chk("blank", 10'h000, l00);
		for (int i = 0; i < 16; i++) begin
			rnd = nxt(rnd);
			words[i] = rnd[15:0] & 16'h0F0F | 16'h2020; // Clear of ramp and controls
			smp = words[i];
			val = 1;
			@(negedge mclk_i);
		end
		smp = 16'hFFFF;
		chk("full0", 0, rdy0);
		chk("full1", 0, rdy1);
		repeat (3) @(negedge mclk_i);
		val = 0;
		// Power up with bypass and offset binary, words must leave in order
		spi(1'b0, 15'h0571, 8'h54);
		seek(byp(words[0][7:0], 1'b1));
		for (int i = 0; i < 16; i++) begin
			chk("l0p0", byp(words[i][7:0], 1'b1), l00);
			chk("l1p0", byp(words[i][15:8], 1'b1), l10);
			chk("l0p1", byp(words[i][7:0], 1'b1), l01);
			chk("l1p1", byp(words[i][15:8], 1'b1), l11);
			@(negedge mclk_i);
		end
		chk("refused", 1, l00 !== byp(8'hFF, 1'b1));
		// Repeated frame end octet with scrambling off
		spi(1'b0, 15'h0571, 8'h06);
		rnd = nxt(rnd);
		smp = rnd[15:0] & 16'h0F0F | 16'h2020;
		val = 1;
		repeat (2) @(negedge mclk_i);
		val = 0;
		seek(byp(smp[7:0], 1'b0));
		@(negedge mclk_i);
		chk("subst", 1, l00 === 10'h0FC || l00 === 10'h07C);
		// Invert after bypass on the idle octet
		spi(1'b0, 15'h0571, 8'h0C);
		repeat (4) @(negedge mclk_i);
		chk("invert", 10'h3FF, l00);
		end_sim();
	end
endmodule // tb
